// File: core/gpio_exp_pkg.sv
// Purpose: constants shared by the i2c gpio expander target
// Assumes: 8-bit port, 7-bit bus address with three strap bits
// Notes:   register offsets, reset values and encodings live here only
package gpio_exp_pkg;

  localparam logic [3:0] ADDR_BASE_HI     = 4'h4;   // upper address bits 0100
  localparam int         ADDR_BITS        = 7;
  localparam int         PORT_WIDTH       = 8;

  // register select codes
  localparam logic [1:0] SEL_PIN_LEVEL_IN = 2'h0;
  localparam logic [1:0] SEL_DRIVE_LATCH  = 2'h1;
  localparam logic [1:0] SEL_INVERT_MASK  = 2'h2;
  localparam logic [1:0] SEL_DIRECTION    = 2'h3;
  localparam int         REG_SELECT_LSB   = 0;
  localparam int         REG_SELECT_MSB   = 1;

  // reset values
  localparam logic [7:0] RST_PIN_LEVEL_IN = 8'hFF;
  localparam logic [7:0] RST_DRIVE_LATCH  = 8'hFF;
  localparam logic [7:0] RST_INVERT_MASK  = 8'h00;
  localparam logic [7:0] RST_DIRECTION    = 8'hFF;
  localparam logic [7:0] RST_POINTER      = 8'h00;

  // direction bit and read/write bit meaning
  localparam logic       DIR_INPUT        = 1'b1;
  localparam logic       RW_READ          = 1'b1;

  // bit counter
  localparam logic [3:0] BIT_LAST         = 4'h7;

endpackage

// File: core/sync_edge.sv
// Purpose: two-stage synchroniser with edge detection for one pin
// Assumes: input is asynchronous to mclk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module sync_edge
(
  input  wire logic mclk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output var  logic level,
  output var  logic rise,
  output var  logic fall
);

  logic meta_reg;
  logic sync_reg;
  logic last_reg;

  // two flops, then a history flop for edges
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      meta_reg <= 1'b1;
      sync_reg <= 1'b1;
      last_reg <= 1'b1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      last_reg <= sync_reg;
    end
  end

  // edges compare stable stages only
  always_comb
  begin
    level = sync_reg;
    rise  = sync_reg & ~last_reg;
    fall  = ~sync_reg & last_reg;
  end

endmodule
`default_nettype wire

// File: core/gpio_expander.sv
// Purpose: i2c target with four 8-bit gpio registers and change interrupt
// Assumes: scl and sda are sampled by mclk, far faster than the bus
// Notes:   sda and the interrupt are open drain, split into out and enable
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Answer address 0100 plus the three strap levels as low bits.
// - Last address bit one means read, zero means write.
// - Byte after acknowledged address goes to a write-only pointer.
// - Two low command bits select level, latch, invert or direction.
// - Reset: level, latch, direction all ones; invert mask all zeros.
// - Level register shows every pin level; writes to it are ignored.
// - Invert mask bit one returns that level bit inverted.
// - Latch bit drives its pin only while that pin is an output.
// - Reading the latch returns stored contents, not the pins.
// - Direction one makes pin a high-impedance input; zero drives it.
// - No auto-increment; pointer stays until a new command byte.
// - Send data while controller acknowledges; no acknowledge ends reading.
// - Capture pin levels into level register at acknowledge clock rise.
// - Stop ends any transfer; last acknowledge capture stays valid.
// - Interrupt low while input pin differs from captured level.
// - Output pins never interrupt; other targets leave interrupt alone.
// - Acknowledge every received byte, data low through the clock high.
module gpio_expander
#(
  parameter int PORT_WIDTH = gpio_exp_pkg::PORT_WIDTH
)
(
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output var  logic                  sda_out,
  output var  logic                  sda_oe,
  input  wire logic                  addr_strap_bit0,
  input  wire logic                  addr_strap_bit1,
  input  wire logic                  addr_strap_bit2,
  input  wire logic [PORT_WIDTH-1:0] io_pins_in,
  output var  logic [PORT_WIDTH-1:0] io_pins_out,
  output var  logic [PORT_WIDTH-1:0] io_pins_oe,
  output var  logic                  int_n_out,
  output var  logic                  int_n_oe
);

  // ==========================================================
  // elaboration check
  if (PORT_WIDTH != 8)
  begin
    $error("gpio_expander serves an 8-bit port only");
  end

  // ==========================================================
  // input synchronisers
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;

  sync_edge scl_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (scl_in),
    .level    (scl),
    .rise     (scl_rise),
    .fall     (scl_fall)
  );

  sync_edge sda_sync
  (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .async_in (sda_in),
    .level    (sda),
    .rise     (sda_rise),
    .fall     (sda_fall)
  );

  logic [PORT_WIDTH-1:0] pin_meta_reg;
  logic [PORT_WIDTH-1:0] pin_sync_reg;
  logic [2:0]            strap_meta_reg;
  logic [2:0]            strap_sync_reg;

  // port pins and straps through two flops
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      pin_meta_reg   <= '1;
      pin_sync_reg   <= '1;
      strap_meta_reg <= 3'h0;
      strap_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg   <= io_pins_in;
      pin_sync_reg   <= pin_meta_reg;
      strap_meta_reg <= {addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
      strap_sync_reg <= strap_meta_reg;
    end
  end

  // ==========================================================
  // bus conditions and byte engine
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK  = 3'b010,
    ST_RECV = 3'b011,
    ST_SEND = 3'b100,
    ST_MACK = 3'b101
  } state_type;

  state_type             state_reg;
  logic [3:0]            bit_cnt_reg;
  logic [7:0]            shift_reg;
  logic                  read_reg;
  logic                  first_byte_reg;
  logic [7:0]            register_pointer_reg;
  logic [PORT_WIDTH-1:0] pin_level_in_reg;
  logic [PORT_WIDTH-1:0] pin_drive_latch_reg;
  logic [PORT_WIDTH-1:0] input_invert_mask_reg;
  logic [PORT_WIDTH-1:0] pin_direction_reg;
  logic                  start_cond;
  logic                  stop_cond;
  logic                  addr_match;
  logic [7:0]            rx_byte;
  logic [1:0]            sel;
  logic [PORT_WIDTH-1:0] tx_value;

  // select field of the pointer
  function automatic logic [PORT_WIDTH-1:0] read_value(input logic [1:0] s);
    unique case (s)
      gpio_exp_pkg::SEL_PIN_LEVEL_IN: read_value = pin_level_in_reg ^ input_invert_mask_reg;
      gpio_exp_pkg::SEL_DRIVE_LATCH:  read_value = pin_drive_latch_reg;
      gpio_exp_pkg::SEL_INVERT_MASK:  read_value = input_invert_mask_reg;
      gpio_exp_pkg::SEL_DIRECTION:    read_value = pin_direction_reg;
    endcase
  endfunction

  // conditions while clock high, address compare
  always_comb
  begin
    start_cond = scl & sda_fall;
    stop_cond  = scl & sda_rise;
    rx_byte    = {shift_reg[6:0], sda};
    addr_match = (rx_byte[7:1] == {gpio_exp_pkg::ADDR_BASE_HI, strap_sync_reg});
    sel        = register_pointer_reg[gpio_exp_pkg::REG_SELECT_MSB:
                                      gpio_exp_pkg::REG_SELECT_LSB];
    tx_value   = read_value(sel);
  end

  // state machine stepped by scl edges
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      read_reg     <= 1'b0;
    end
    else if (start_cond)
    begin
      state_reg    <= ST_ADDR;
      bit_cnt_reg  <= 4'h0;
    end
    else if (stop_cond)
      state_reg <= ST_IDLE;
    else
    begin
      unique case (state_reg)
        ST_IDLE: ;
        ST_ADDR, ST_RECV:
          if (scl_rise)
          begin
            shift_reg   <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == gpio_exp_pkg::BIT_LAST)
            begin
              if (state_reg == ST_ADDR)
              begin
                read_reg  <= (rx_byte[0] == gpio_exp_pkg::RW_READ);
                state_reg <= addr_match ? ST_ACK : ST_IDLE;
              end
              else
                state_reg <= ST_ACK;
            end
          end
        ST_ACK:
          if (scl_fall && bit_cnt_reg == 4'h8)
            bit_cnt_reg <= 4'h9;
          else if (scl_fall && bit_cnt_reg == 4'h9)
          begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= read_reg ? ST_SEND : ST_RECV;
          end
        ST_SEND:
          if (scl_fall)
          begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == gpio_exp_pkg::BIT_LAST)
              state_reg <= ST_MACK;
          end
        // nack ends the read; after an ack wait for the fall to send bit 7
        ST_MACK:
          if (scl_rise && sda)
            state_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= ST_SEND;
          end
      endcase
    end
  end

  // ==========================================================
  // pointer and register writes at end of received bytes
  logic byte_done;

  always_comb
  begin
    byte_done = !start_cond && !stop_cond && state_reg == ST_RECV && scl_rise
                && bit_cnt_reg == gpio_exp_pkg::BIT_LAST;
  end

  // first data byte is the command, then data to the same register
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      register_pointer_reg  <= gpio_exp_pkg::RST_POINTER;
      pin_drive_latch_reg   <= gpio_exp_pkg::RST_DRIVE_LATCH;
      input_invert_mask_reg <= gpio_exp_pkg::RST_INVERT_MASK;
      pin_direction_reg     <= gpio_exp_pkg::RST_DIRECTION;
      first_byte_reg        <= 1'b1;
    end
    else
    begin
      if (start_cond)
        first_byte_reg <= 1'b1;
      if (byte_done)
      begin
        first_byte_reg <= 1'b0;
        if (first_byte_reg)
          register_pointer_reg <= rx_byte;
        else
        begin
          unique case (sel)
            gpio_exp_pkg::SEL_PIN_LEVEL_IN: ;
            gpio_exp_pkg::SEL_DRIVE_LATCH:  pin_drive_latch_reg   <= rx_byte;
            gpio_exp_pkg::SEL_INVERT_MASK:  input_invert_mask_reg <= rx_byte;
            gpio_exp_pkg::SEL_DIRECTION:    pin_direction_reg     <= rx_byte;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // input capture and change interrupt
  logic ack_capture;
  logic int_pending;

  always_comb
  begin
    ack_capture = (state_reg == ST_MACK) && scl_rise;
    int_pending = |((pin_sync_reg ^ pin_level_in_reg) & pin_direction_reg);
  end

  // levels set to all ones at reset, captured at each read acknowledge
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
      pin_level_in_reg <= gpio_exp_pkg::RST_PIN_LEVEL_IN;
    else if (ack_capture)
      pin_level_in_reg <= pin_sync_reg;
  end

  // ==========================================================
  // output drivers, all from flops
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      sda_out     <= 1'b0;
      sda_oe      <= 1'b0;
      io_pins_out <= '0;
      io_pins_oe  <= '0;
      int_n_out   <= 1'b0;
      int_n_oe    <= 1'b0;
    end
    else
    begin
      sda_out     <= 1'b0;
      io_pins_out <= pin_drive_latch_reg;
      io_pins_oe  <= ~pin_direction_reg;
      int_n_out   <= 1'b0;
      int_n_oe    <= int_pending;
      if (start_cond || stop_cond)
        sda_oe <= 1'b0;
      else if (state_reg == ST_ACK && scl_fall && bit_cnt_reg == 4'h8)
        sda_oe <= 1'b1;
      else if (state_reg == ST_ACK && scl_fall && bit_cnt_reg == 4'h9)
        sda_oe <= read_reg && !tx_value[7];
      else if (state_reg == ST_SEND && scl_fall)
        sda_oe <= (bit_cnt_reg != gpio_exp_pkg::BIT_LAST)
                  && !tx_value[3'(6 - bit_cnt_reg)];
      else if (state_reg == ST_MACK && scl_rise && !sda)
        sda_oe <= 1'b0;
      else if (state_reg == ST_MACK && scl_fall)
        sda_oe <= !tx_value[7];
      else if ((state_reg == ST_RECV || state_reg == ST_ADDR) && scl_fall)
        sda_oe <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: dv/gpio_expander_chk.sv
// Purpose: port timing checks for the gpio expander
// Assumes: one clock domain, synchronous active-low reset
// Notes:   bound to every gpio_expander instance
`timescale 1ns/1ps
`default_nettype none
module gpio_expander_chk
#(
  parameter int PORT_WIDTH = 8
)
(
  input wire logic                  mclk,
  input wire logic                  reset_n,
  input wire logic                  scl_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe,
  input wire logic [PORT_WIDTH-1:0] io_pins_out,
  input wire logic [PORT_WIDTH-1:0] io_pins_oe,
  input wire logic                  int_n_out,
  input wire logic                  int_n_oe
);
  // ==========================================
  // length of the current scl high stretch
  logic [3:0] hi_cnt;
  always_ff @(posedge mclk)
  begin
    if (!reset_n || !scl_in)
      hi_cnt <= 4'h0;
    else if (hi_cnt != 4'hF)
      hi_cnt <= hi_cnt + 4'h1;
  end
  // ==========================================
  // properties
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  sequence s_held;
    sda_oe [*5];
  endsequence
  sequence s_all_out;
    (io_pins_oe == {PORT_WIDTH{1'b1}}) [*4];
  endsequence
  property p_od_low;
    !sda_out && !int_n_out;
  endproperty
  property p_ack_edge;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  property p_ack_hold;
    $rose(scl_in) && sda_oe |-> s_held;
  endproperty
  property p_rst;
    $rose(reset_n) |-> (io_pins_oe == '0 && !sda_oe) [*4];
  endproperty
  property p_quiet;
    (hi_cnt > 4'hC) |-> $stable(io_pins_out) && $stable(io_pins_oe);
  endproperty
  property p_idle;
    (hi_cnt > 4'h6) |-> !sda_oe;
  endproperty
  property p_no_int;
    s_all_out |-> !int_n_oe;
  endproperty
  property p_bound;
    $rose(sda_oe) |-> ##[1:240] !sda_oe;
  endproperty
  a_od_low: assert property (p_od_low) else $error("drive level not low");
  a_ack_edge: assert property (p_ack_edge) else $error("sda moved in scl high");
  a_ack_hold: assert property (p_ack_hold) else $error("ack dropped early");
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  a_quiet: assert property (p_quiet) else $error("pins moved on idle bus");
  a_idle: assert property (p_idle) else $error("sda held on idle bus");
  a_no_int: assert property (p_no_int) else $error("interrupt from outputs");
  a_bound: assert property (p_bound) else $error("sda held too long");
endmodule
bind gpio_expander gpio_expander_chk #(.PORT_WIDTH(PORT_WIDTH)) i_gpio_expander_chk (
  .mclk(mclk), .reset_n(reset_n), .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .io_pins_out(io_pins_out), .io_pins_oe(io_pins_oe), .int_n_out(int_n_out),
  .int_n_oe(int_n_oe));
`default_nettype wire

// File: dv/i2c_ctrl_model.sv
// Purpose: behavioural bus controller
// Assumes: pull-up on sda, 64 ns bit period
// Notes:   the bench calls its tasks
`timescale 1ns/1ps
`default_nettype none
module i2c_ctrl_model
(
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  // ==========================================
  // bus idle: scl high, sda released
  initial
  begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end
  // drive in low phase, sample late in high phase
  task automatic slot(input logic b, output logic s);
    scl = 1'b0;
    #8 sda_pull = ~b;
    #32 scl = 1'b1;
    #24 s = sda;
  endtask
  // start, also used as repeated start
  task automatic start;
    scl = 1'b0;
    #8 sda_pull = 1'b0;
    #32 scl = 1'b1;
    #12 sda_pull = 1'b1;
    #12;
  endtask
  task automatic stop;
    scl = 1'b0;
    #8 sda_pull = 1'b1;
    #32 scl = 1'b1;
    #12 sda_pull = 1'b0;
    #12;
  endtask
  // msb first, then free slot for the target's ack
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      slot(d[i], s);
    slot(1'b1, s);
    ack = ~s;
  endtask
  // ak low on the last wanted byte
  task automatic get(input logic ak, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, s);
      d[i] = s;
    end
    slot(~ak, s);
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// Purpose: self-checking bench for the gpio expander
// Assumes: straps 101, own address 25h
// Notes:   level reads compare the byte after a capture
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] own_wr = {gpio_exp_pkg::ADDR_BASE_HI, 3'h5, 1'b0};
  localparam logic [7:0] own_rd = own_wr | 8'h01;
  localparam logic [7:0] far_tab [4] = '{8'h40, 8'h48, 8'h4E, 8'hCA};
  logic       mclk, reset_n, sda_oe, sda_out, int_n_out, int_n_oe, ack_adr, ack_cmd, ack_dat;
  logic       scl, sda_pull;
  logic [2:0] straps;
  logic [7:0] pins_ext, pins_in, pins_out, pins_oe, byte_first, byte_second;
  wire logic  sda;
  int         bad_count = 0, total_checks = 0, cycles = 0;
  assign sda     = ~(sda_pull | sda_oe);
  assign pins_in = (pins_oe & pins_out) | (~pins_oe & pins_ext);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  i2c_ctrl_model i_i2c_ctrl_model (.sda(sda), .scl(scl), .sda_pull(sda_pull));
  gpio_expander i_gpio_expander (
    .mclk(mclk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_strap_bit0(straps[0]), .addr_strap_bit1(straps[1]),
    .addr_strap_bit2(straps[2]), .io_pins_in(pins_in), .io_pins_out(pins_out),
    .io_pins_oe(pins_oe), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  // ==========================================
  // compare, report, bus tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.put(own_wr, ack_adr);
    i_i2c_ctrl_model.put(c, ack_cmd);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    cmd(c);
    i_i2c_ctrl_model.put(d, ack_dat);
    i_i2c_ctrl_model.stop();
    chk({7'h00, ack_adr & ack_cmd & ack_dat}, 8'h01);
  endtask
  // read two bytes from the current pointer, ack then nack
  task automatic again(input logic both, input logic [7:0] e);
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.put(own_rd, ack_dat);
    i_i2c_ctrl_model.get(1'b1, byte_first);
    i_i2c_ctrl_model.get(1'b0, byte_second);
    i_i2c_ctrl_model.stop();
    chk({7'h00, ack_dat}, 8'h01);
    if (both)
      chk(byte_first, e);
    chk(byte_second, e);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] e);
    cmd(c);
    again(c != 8'h00, e);
  endtask
  task automatic probe(input logic [7:0] a, input logic [7:0] e);
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.put(a, ack_adr);
    i_i2c_ctrl_model.stop();
    chk({7'h00, ack_adr}, e);
  endtask
  // look after the edge so the registered flag has settled
  task automatic int_is(input logic e);
    repeat (10) @(posedge mclk);
    #1 chk({7'h00, int_n_oe}, {7'h00, e});
  endtask
  task automatic pins(input logic [7:0] v);
    @(posedge mclk);
    #1 pins_ext = v;
  endtask
  // hang guard
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      end_of_test();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    reset_n  = 1'b0;
    pins_ext = 8'hFF;
    straps   = 3'h5;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    rd(8'h00, 8'hFF);
    rd(8'h01, 8'hFF);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'hFF);
    wr(8'h01, 8'h3C);
    wr(8'h02, 8'h0F);
    wr(8'h03, 8'hF0);
    pins(8'h5A);
    int_is(1'b1);
    chk(pins_oe, 8'h0F);
    chk(pins_out & pins_oe, 8'h0C);
    rd(8'h00, 8'h53);
    int_is(1'b0);
    rd(8'h01, 8'h3C);
    wr(8'h00, 8'h00);
    rd(8'h00, 8'h53);
    pins(8'hDA);
    int_is(1'b1);
    pins(8'h5A);
    int_is(1'b0);
    wr(8'h01, 8'h33);
    int_is(1'b0);
    pins(8'hDA);
    int_is(1'b1);
    foreach (far_tab[i]) probe(far_tab[i], 8'h00);
    int_is(1'b1);
    probe(own_wr, 8'h01);
    rd(8'h00, 8'hDC);
    int_is(1'b0);
    cmd(8'h01);
    i_i2c_ctrl_model.put(8'h11, ack_adr);
    i_i2c_ctrl_model.put(8'h22, ack_dat);
    i_i2c_ctrl_model.stop();
    chk({7'h00, ack_adr & ack_cmd & ack_dat}, 8'h01);
    again(1'b1, 8'h22);
    chk(pins_out & pins_oe, 8'h02);
    cmd(8'h03);
    i_i2c_ctrl_model.stop();
    again(1'b1, 8'hF0);
    wr(8'h03, 8'h00);
    int_is(1'b0);
    chk(pins_oe, 8'hFF);
    // new strap levels move the answered address
    @(posedge mclk);
    #1 straps = 3'h2;
    repeat (4) @(posedge mclk);
    probe(8'h44, 8'h01);
    probe(own_wr, 8'h00);
    end_of_test();
  end
endmodule
`default_nettype wire
